// File: common/trbg_consts.svh
// Register offsets, reset values and timing counts for the timer reload and baud block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef TRBG_CONSTS_SVH
`define TRBG_CONSTS_SVH
`define TRBG_ADDR_T0_LOW 8'h8a
`define TRBG_ADDR_T0_HIGH 8'h8c
`define TRBG_ADDR_T3_RLH 8'h93
`define TRBG_ADDR_T2_RLH 8'hcb
`define TRBG_BYTE_RESET 8'h00
`define TRBG_DIV4_COUNT 6'h04
`define TRBG_DIV12_COUNT 6'h0c
`define TRBG_DIV48_COUNT 6'h30
`define TRBG_EXT_DIV8_COUNT 3'h7
`endif

// File: common/trbg_pkg.sv
// Types for the timer reload and baud block
package trbg_pkg;
  typedef enum logic [2:0] {
    TRBG_SRC_SYS,
    TRBG_SRC_DIV4,
    TRBG_SRC_DIV12,
    TRBG_SRC_DIV48,
    TRBG_SRC_EXT8,
    TRBG_SRC_PIN
  } trbg_src_type;
  typedef enum logic [1:0] {
    TRBG_MODE_RELOAD,
    TRBG_MODE_CAPTURE
  } trbg_mode_type;
endpackage

// File: verilog/trbg_prescale.sv
// Timer one clock source selection: one-cycle tick enables
`timescale 1ns/1ps
`default_nettype none
`include "trbg_consts.svh"
module trbg_prescale (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [2:0] src_sel, // Clock source select
  input wire logic ext_osc_tick, // External oscillator edge, one cycle
  input wire logic ext_pin, // External input level
  output logic tick // One-cycle timer one count enable
);
  logic [5:0] div_ff;
  logic [5:0] nxt_div;
  logic [2:0] ext_ff;
  logic [2:0] nxt_ext;
  logic pin_ff;
  logic nxt_pin;
  logic tick_ff;
  logic nxt_tick;

  // Divide test, shared by every system clock divider
  function automatic logic hit(input logic [5:0] cnt, input logic [5:0] lim);
    hit = (cnt == lim - 6'h01);
  endfunction

  // Free-running divider, a shared count keeps dividers phase locked
  always_comb
  begin
    nxt_div = (div_ff == `TRBG_DIV48_COUNT - 6'h01) ? 6'h00 : div_ff + 6'h01;
    nxt_ext = ext_osc_tick ? ext_ff + 3'h1 : ext_ff;
    nxt_pin = ext_pin;
    case (src_sel)
      trbg_pkg::TRBG_SRC_SYS: nxt_tick = 1'b1;
      trbg_pkg::TRBG_SRC_DIV4: nxt_tick = hit({4'h0, div_ff[1:0]}, `TRBG_DIV4_COUNT);
      trbg_pkg::TRBG_SRC_DIV12: nxt_tick = hit(div_ff % 6'h0c, `TRBG_DIV12_COUNT);
      trbg_pkg::TRBG_SRC_DIV48: nxt_tick = hit(div_ff, `TRBG_DIV48_COUNT);
      trbg_pkg::TRBG_SRC_EXT8: nxt_tick = ext_osc_tick && (ext_ff == `TRBG_EXT_DIV8_COUNT);
      trbg_pkg::TRBG_SRC_PIN: nxt_tick = pin_ff && !ext_pin; // Falling edge counts
      default: nxt_tick = 1'b0;
    endcase
  end

  // Registers only
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      div_ff <= 6'h00;
      ext_ff <= 3'h0;
      pin_ff <= 1'b0;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      ext_ff <= nxt_ext;
      pin_ff <= nxt_pin;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule
`default_nettype wire

// File: verilog/trbg_top.sv
// Timer byte registers, reload high bytes and baud tick generator
`timescale 1ns/1ps
`default_nettype none
`include "trbg_consts.svh"
module trbg_top (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst, // Async reset, active high
  input wire logic [7:0] sfr_addr, // Special register address
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  output logic [7:0] sfr_rdata, // Read data, one cycle after strobe
  input wire logic [1:0] timer_two_mode, // Reload or capture mode
  input wire logic timer_two_reload, // Timer two reload event
  input wire logic timer_two_capture, // Timer two capture event
  input wire logic [7:0] timer_two_count_high, // Timer two count high byte
  output logic [7:0] timer_two_load_high, // Value loaded on reload
  input wire logic [1:0] timer_three_mode, // Reload or capture mode
  input wire logic timer_three_reload, // Timer three reload event
  input wire logic timer_three_capture, // Timer three capture event
  input wire logic [7:0] timer_three_count_high, // Timer three count high byte
  output logic [7:0] timer_three_load_high, // Value loaded on reload
  input wire logic timer_one_run, // Timer one run enable
  input wire logic [2:0] timer_one_src, // Timer one clock select
  input wire logic [7:0] timer_one_reload, // Timer one reload high byte
  input wire logic ext_osc_tick, // External oscillator edge
  input wire logic timer_one_external_input, // External count pin
  output logic [7:0] timer_one_count, // Timer one low count byte
  output logic timer_one_overflow, // Overflow pulse
  output logic serial_port_zero_baud // Baud pulse, half overflow rate
);
  logic [7:0] t0_low_ff;
  logic [7:0] nxt_t0_low;
  logic [7:0] t0_high_ff;
  logic [7:0] nxt_t0_high;
  logic [7:0] t2_rlh_ff;
  logic [7:0] nxt_t2_rlh;
  logic [7:0] t3_rlh_ff;
  logic [7:0] nxt_t3_rlh;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] t1_ff;
  logic [7:0] nxt_t1;
  logic ovf_ff;
  logic nxt_ovf;
  logic half_ff;
  logic nxt_half;
  logic baud_ff;
  logic nxt_baud;
  logic tick;
  logic t1_wrap;

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------

  // Reload byte update; hardware capture wins over a software write
  function automatic logic [7:0] rlh_next(input logic [7:0] cur, input logic wr_hit,
    input logic [7:0] wdata, input logic [1:0] mode, input logic cap,
    input logic [7:0] cnt);
    rlh_next = wr_hit ? wdata : cur;
    if (mode == trbg_pkg::TRBG_MODE_CAPTURE && cap)
      rlh_next = cnt;
  endfunction

  // Write decode, shared by every writable byte
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
    input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  // Timer zero bytes are storage only; the counter that steps them lives outside,
  // so a write here is all that ever changes them. The reload and capture events
  // of timers two and three are consumed outside as well; only capture lands here.
  always_comb
  begin
    nxt_t0_low = wr_hit(sfr_wr, sfr_addr, `TRBG_ADDR_T0_LOW) ? sfr_wdata : t0_low_ff;
    nxt_t0_high = wr_hit(sfr_wr, sfr_addr, `TRBG_ADDR_T0_HIGH) ? sfr_wdata : t0_high_ff;
  end

  // Timer zero registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      t0_low_ff <= `TRBG_BYTE_RESET;
      t0_high_ff <= `TRBG_BYTE_RESET;
    end
    else
    begin
      t0_low_ff <= nxt_t0_low;
      t0_high_ff <= nxt_t0_high;
    end
  end

  // Reload bytes; a capture in the cycle of a write keeps the captured count
  always_comb
  begin
    nxt_t2_rlh = rlh_next(t2_rlh_ff, wr_hit(sfr_wr, sfr_addr, `TRBG_ADDR_T2_RLH),
      sfr_wdata, timer_two_mode, timer_two_capture, timer_two_count_high);
    nxt_t3_rlh = rlh_next(t3_rlh_ff, wr_hit(sfr_wr, sfr_addr, `TRBG_ADDR_T3_RLH),
      sfr_wdata, timer_three_mode, timer_three_capture, timer_three_count_high);
  end

  // Reload byte registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      t2_rlh_ff <= `TRBG_BYTE_RESET;
      t3_rlh_ff <= `TRBG_BYTE_RESET;
    end
    else
    begin
      t2_rlh_ff <= nxt_t2_rlh;
      t3_rlh_ff <= nxt_t3_rlh;
    end
  end

  // Read data holds the last value read, so a late sample still sees it
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (sfr_rd)
    begin
      case (sfr_addr)
        `TRBG_ADDR_T0_LOW: nxt_rdata = t0_low_ff;
        `TRBG_ADDR_T0_HIGH: nxt_rdata = t0_high_ff;
        `TRBG_ADDR_T2_RLH: nxt_rdata = t2_rlh_ff;
        `TRBG_ADDR_T3_RLH: nxt_rdata = t3_rlh_ff;
        default: nxt_rdata = 8'h00; // Unmapped reads as zero
      endcase
    end
  end

  // Read data register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  // Reload bytes drive the timers' high byte on reload
  assign timer_two_load_high = t2_rlh_ff;
  assign timer_three_load_high = t3_rlh_ff;
  assign sfr_rdata = rdata_ff;

  // ----------------------------------------------------------------------------
  // Timer one and baud divider
  // ----------------------------------------------------------------------------

  trbg_prescale u_prescale (
    .sys_clk(sys_clk),
    .rst(rst),
    .src_sel(timer_one_src),
    .ext_osc_tick(ext_osc_tick),
    .ext_pin(timer_one_external_input),
    .tick(tick)
  );

  // 8-bit auto-reload count; the wrap flag also feeds the baud halver
  always_comb
  begin
    t1_wrap = timer_one_run && tick && (t1_ff == 8'hff);
    nxt_t1 = t1_ff;
    if (t1_wrap)
      nxt_t1 = timer_one_reload;
    else if (timer_one_run && tick)
      nxt_t1 = t1_ff + 8'h01;
    nxt_ovf = t1_wrap;
  end

  // Count and overflow registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      t1_ff <= 8'h00;
      ovf_ff <= 1'b0;
    end
    else
    begin
      t1_ff <= nxt_t1;
      ovf_ff <= nxt_ovf;
    end
  end

  // Baud halver: every second overflow gives one bit-rate pulse, in step with it
  always_comb
  begin
    nxt_half = t1_wrap ? !half_ff : half_ff;
    nxt_baud = t1_wrap && half_ff;
  end

  // Halver registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      half_ff <= 1'b0;
      baud_ff <= 1'b0;
    end
    else
    begin
      half_ff <= nxt_half;
      baud_ff <= nxt_baud;
    end
  end

  assign timer_one_count = t1_ff;
  assign timer_one_overflow = ovf_ff;
  assign serial_port_zero_baud = baud_ff;
endmodule
`default_nettype wire

// File: testbench/trbg_top_props.sv
// Port checker for the timer reload and baud block
`timescale 1ns/1ps
`default_nettype none
module trbg_top_props (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] sfr_addr, // Address
  input wire logic [7:0] sfr_wdata, // Wdata
  input wire logic sfr_wr, // Write
  input wire logic sfr_rd, // Read
  input wire logic [7:0] sfr_rdata, // Rdata
  input wire logic [1:0] timer_two_mode, // Mode
  input wire logic timer_two_capture, // Capture
  input wire logic [7:0] timer_two_count_high, // Count
  input wire logic [7:0] timer_two_load_high, // Reload
  input wire logic [1:0] timer_three_mode, // Mode
  input wire logic timer_three_capture, // Capture
  input wire logic [7:0] timer_three_count_high, // Count
  input wire logic [7:0] timer_three_load_high, // Reload
  input wire logic timer_one_run, // Run
  input wire logic [7:0] timer_one_reload, // Reload
  input wire logic [7:0] timer_one_count, // Count
  input wire logic timer_one_overflow, // Overflow
  input wire logic serial_port_zero_baud // Baud
);
  logic odd_ff;
  logic nxt_odd;
  default clocking clk_cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------
  // Overflow parity; baud needs every second
  // ---------------------------------------
  always_comb nxt_odd = odd_ff ^ timer_one_overflow;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      odd_ff <= 1'h0;
    else
      odd_ff <= nxt_odd;
  // Write, one idle cycle, then read back at one address
  sequence wr_rd(a);
    sfr_wr && sfr_addr == a ##1 !sfr_wr ##1 sfr_rd && sfr_addr == a;
  endsequence
  a_low_readback: assert property (wr_rd(8'h8a) |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("low byte readback wrong");
  a_high_readback: assert property (wr_rd(8'h8c) |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("high byte readback wrong");
  a_two_write: assert property (sfr_wr && sfr_addr == 8'hcb && !timer_two_capture
    |=> timer_two_load_high == $past(sfr_wdata)) else $error("timer two reload not written");
  a_two_capture: assert property (timer_two_mode == 2'h1 && timer_two_capture
    |=> timer_two_load_high == $past(timer_two_count_high)) else $error("timer two capture");
  a_three_write: assert property (sfr_wr && sfr_addr == 8'h93 && !timer_three_capture
    |=> timer_three_load_high == $past(sfr_wdata)) else $error("timer three reload");
  a_three_capture: assert property (timer_three_mode == 2'h1 && timer_three_capture
    |=> timer_three_load_high == $past(timer_three_count_high)) else $error("three capture");
  a_ovf_reload: assert property (timer_one_overflow |-> timer_one_count == $past(timer_one_reload))
    else $error("overflow without reload");
  a_baud_half: assert property (serial_port_zero_baud == (timer_one_overflow && odd_ff))
    else $error("baud pulse misplaced");
  a_stop_hold: assert property (!timer_one_run [*3] |=> $stable(timer_one_count))
    else $error("count moved while stopped");
endmodule
bind trbg_top trbg_top_props u_props (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .timer_two_mode(timer_two_mode), .timer_two_capture(timer_two_capture),
  .timer_two_count_high(timer_two_count_high), .timer_two_load_high(timer_two_load_high),
  .timer_three_mode(timer_three_mode), .timer_three_capture(timer_three_capture),
  .timer_three_count_high(timer_three_count_high),
  .timer_three_load_high(timer_three_load_high), .timer_one_run(timer_one_run),
  .timer_one_reload(timer_one_reload), .timer_one_count(timer_one_count),
  .timer_one_overflow(timer_one_overflow), .serial_port_zero_baud(serial_port_zero_baud));
`default_nettype wire

// File: testbench/trbg_top_tb.sv
// Self-checking bench for the timer reload and baud block
`timescale 1ns/1ps
`default_nettype none
module trbg_top_tb;
  logic sys_clk = 0, rst = 1, wr = 0, rd = 0, c2 = 0, c3 = 0, run = 0, ot = 0, pin = 0;
  logic [7:0] a = 0, wd = 0, h2 = 0, h3 = 0, r1 = 0, rdat, l2, l3, cnt, prv;
  logic [2:0] src = 0;
  logic [1:0] m2 = 0, m3 = 0;
  logic ovf, bd;
  int error_cnt = 0, samples_checked = 0, cyc = 0, chg = 0, no = 0, nb = 0;
  logic [7:0] rows [5][3] = '{'{8'h8a, 8'ha5, 8'ha5}, '{8'h8c, 8'h5a, 8'h5a},
    '{8'hcb, 8'h3c, 8'h3c}, '{8'h93, 8'hc3, 8'hc3}, '{8'h55, 8'hff, 8'h00}};
  int dv [6] = '{1, 4, 12, 48, 16, 8};
  trbg_top u_dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(a), .sfr_wdata(wd), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_rdata(rdat), .timer_two_mode(m2), .timer_two_reload(1'h0),
    .timer_two_capture(c2), .timer_two_count_high(h2), .timer_two_load_high(l2),
    .timer_three_mode(m3), .timer_three_reload(1'h0), .timer_three_capture(c3),
    .timer_three_count_high(h3), .timer_three_load_high(l3), .timer_one_run(run),
    .timer_one_src(src), .timer_one_reload(r1), .ext_osc_tick(ot),
    .timer_one_external_input(pin), .timer_one_count(cnt), .timer_one_overflow(ovf),
    .serial_port_zero_baud(bd));
  initial forever #5 sys_clk = ~sys_clk;
  // Free-running sources, count watch and hang guard
  always @(negedge sys_clk)
  begin
    cyc++;
    ot = cyc[0];
    pin = cyc[2];
    chg += int'(cnt !== prv);
    no += int'(ovf);
    nb += int'(bd);
    prv = cnt;
    if (cyc == 9000)
    begin
      error_cnt++;
      print_verdict;
    end
  end
  task chk(input logic [15:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Strobes drop a cycle before the next may rise
  task wrt(input logic [7:0] ad, d);
    a = ad;
    wd = d;
    wr = 1;
    @(negedge sys_clk);
    wr = 0;
    @(negedge sys_clk);
  endtask
  task rdc(input logic [7:0] ad, e);
    a = ad;
    rd = 1;
    @(negedge sys_clk);
    rd = 0;
    @(negedge sys_clk);
    chk(rdat, e);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge sys_clk);
    rst = 0;
    @(negedge sys_clk);
    for (int i = 0; i < 5; i++)
    begin
      rdc(rows[i][0], 8'h00);
      wrt(rows[i][0], rows[i][1]);
      rdc(rows[i][0], rows[i][2]);
    end
    chk(l2, 8'h3c);
    chk(l3, 8'hc3);
    // Capture on both timers with a timer two write: capture must win
    m2 = 1;
    m3 = 1;
    h2 = 8'h77;
    h3 = 8'h88;
    c2 = 1;
    c3 = 1;
    wrt(8'hcb, 8'h11);
    c2 = 0;
    c3 = 0;
    rdc(8'hcb, 8'h77);
    rdc(8'h93, 8'h88);
    chk(l3, 8'h88);
    chk(l2, 8'h77);
    // Short reload gives an overflow every two ticks
    r1 = 8'hfe;
    run = 1;
    no = 0;
    nb = 0;
    repeat (700) @(negedge sys_clk);
    r1 = 8'h00;
    chk(16'(no > 200), 16'h1);
    chk(16'(nb), 16'(no / 2));
    for (int s = 0; s < 6; s++)
    begin
      src = 3'(s);
      repeat (8) @(negedge sys_clk);
      chg = 0;
      repeat (480) @(negedge sys_clk);
      chk(16'(chg + 1 - 480 / dv[s] <= 2 && chg + 1 >= 480 / dv[s]), 16'h1);
    end
    run = 0;
    rst = 1;
    @(negedge sys_clk);
    rst = 0;
    @(negedge sys_clk);
    rdc(8'h8a, 8'h00);
    chk(l2, 8'h00);
    chk(l3, 8'h00);
    chk(cnt, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
